/* File: common/pmc_pkg.sv */
// Constants and types shared by the power mode clock controller files.
package pmc_pkg;

   // Register byte offsets on the bus (low address bits).
   localparam logic [3:0] PMC_OFS_MODE   = 4'h0;
   localparam logic [3:0] PMC_OFS_CFG    = 4'h4;
   localparam logic [3:0] PMC_OFS_STATUS = 4'h8;

   // System mode register fields.
   localparam int PMC_MODE_HIGH_LOW_CLOCK_SELECT_BIT = 0;
   localparam int PMC_MODE_IDLE_BIT  = 1;
   localparam int PMC_MODE_HRDY_BIT  = 2;
   localparam int PMC_MODE_LRDY_BIT  = 3;
   localparam int PMC_MODE_FAST_BIT  = 4;
   localparam int PMC_MODE_CKS_LSB   = 5;
   localparam logic [7:0] PMC_MODE_RST     = 8'h03;
   localparam logic [7:0] PMC_MODE_WR_MASK = 8'hF3;

   // Watchdog and source configuration register fields.
   localparam int PMC_CFG_KEEP_BIT   = 0;
   localparam int PMC_CFG_LVD_BIT    = 1;
   localparam int PMC_CFG_WDTEN_BIT  = 2;
   localparam int PMC_CFG_WDTSRC_BIT = 3;
   localparam int PMC_CFG_LSSRC_BIT  = 4;
   localparam int PMC_CFG_HSSRC_LSB  = 5;
   localparam logic [7:0] PMC_CFG_RST = 8'h04;

   // Divide select codes at or below this pick the low speed clock.
   localparam logic [2:0] PMC_CKS_LOW_MAX  = 3'h1;
   localparam logic [3:0] PMC_DIV_LOG2_TOP = 4'h8;
   localparam logic [2:0] PMC_LOG2_ONE     = 3'h0;
   localparam logic [2:0] PMC_LOG2_SYS4    = 3'h2;
   localparam logic [31:0] PMC_ZERO_WORD   = 32'h0000_0000;

   typedef enum logic [1:0] {
      PMC_HS_XTAL = 2'b00,
      PMC_HS_ERC  = 2'b01,
      PMC_HS_IRC  = 2'b10
   } pmc_hs_src_t;

   typedef enum logic [2:0] {
      PMC_ST_RUN          = 3'b000,
      PMC_ST_DEEP_SLEEP   = 3'b001,
      PMC_ST_LIGHT_SLEEP  = 3'b010,
      PMC_ST_IDLE_OSC_OFF = 3'b011,
      PMC_ST_IDLE_OSC_ON  = 3'b100,
      PMC_ST_WAKE         = 3'b101
   } pmc_mode_t;

endpackage

/* File: tb/pmc_core_model.sv */
// Core and oscillator model: halt and wake strobes, source ticks.
`timescale 1ns/1ps
module pmc_core_model (
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   input  wire logic halt_req_i,
   input  wire logic wake_req_i,
   output logic      halt_o,
   output logic      wake_o,
   output logic      xtal_high_o,
   output logic      rc_ext_o,
   output logic      rc_high_o,
   output logic      xtal_low_o,
   output logic      rc_low_o
);
   logic [3:0] phase;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         phase  <= 4'h0;
         halt_o <= 1'h0;
         wake_o <= 1'h0;
      end else begin
         phase  <= phase + 4'h1;
         halt_o <= halt_req_i;
         wake_o <= wake_req_i;
      end
   end
   // Each source ticks at its own rate so the bench can tell them apart.
   assign xtal_high_o = reset_n_i;
   assign rc_ext_o    = phase[0];
   assign rc_high_o   = (phase[1:0] == 2'h0);
   assign xtal_low_o  = (phase[2:0] == 3'h0);
   assign rc_low_o    = (phase == 4'h0);
endmodule // pmc_core_model

/* File: tb/pmc_ctl_monitor.sv */
// Port-level assertions for the power mode clock controller.
`timescale 1ns/1ps
module pmc_ctl_monitor #(
   parameter int WAKE_SUB_TICKS = 8,
   parameter int DIV_CW         = 6
) (
   input wire logic               clk_i,
   input wire logic               reset_n_i,
   input wire logic               wb_ack_o,
   input wire logic               halt_i,
   input wire logic               cpu_clock_tick_o,
   input wire logic               system_clock_signal_o,
   input wire logic               substitute_clock_o,
   input wire logic               watchdog_clock_o,
   input wire logic               watchdog_enable_o,
   input wire logic               high_osc_enable_o,
   input wire logic               low_osc_enable_o,
   input wire pmc_pkg::pmc_mode_t mode_o
);
   import pmc_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   // Ticks lag the state by up to two cycles, hence three settled cycles.
   property p_deep_quiet;
      (mode_o == PMC_ST_DEEP_SLEEP) [*3] |->
         !cpu_clock_tick_o && !substitute_clock_o && !watchdog_clock_o;
   endproperty
   a_deep_quiet: assert property (p_deep_quiet)
      else $error("clock tick during deep sleep");

   property p_deep_wdt;
      mode_o == PMC_ST_DEEP_SLEEP |-> !watchdog_enable_o;
   endproperty
   a_deep_wdt: assert property (p_deep_wdt)
      else $error("watchdog enabled during deep sleep");

   property p_light_cpu;
      (mode_o == PMC_ST_LIGHT_SLEEP) [*3] |->
         !cpu_clock_tick_o && !system_clock_signal_o;
   endproperty
   a_light_cpu: assert property (p_light_cpu)
      else $error("core clocked during light sleep");

   property p_idle_off;
      (mode_o == PMC_ST_IDLE_OSC_OFF) [*3] |->
         !cpu_clock_tick_o && !system_clock_signal_o;
   endproperty
   a_idle_off: assert property (p_idle_off)
      else $error("system clock runs in idle with oscillator off");

   property p_idle_on_cpu;
      (mode_o == PMC_ST_IDLE_OSC_ON) [*3] |-> !cpu_clock_tick_o;
   endproperty
   a_idle_on_cpu: assert property (p_idle_on_cpu)
      else $error("core clocked in idle with oscillator on");

   property p_idle_on_osc;
      (mode_o == PMC_ST_IDLE_OSC_ON) [*2] |->
         high_osc_enable_o || low_osc_enable_o;
   endproperty
   a_idle_on_osc: assert property (p_idle_on_osc)
      else $error("oscillator stopped in idle with oscillator on");

   property p_halt;
      halt_i && !$past(halt_i) && mode_o == PMC_ST_RUN |->
         ##[1:2] mode_o != PMC_ST_RUN;
   endproperty
   a_halt: assert property (p_halt)
      else $error("halt in run left the mode unchanged");

   property p_wake;
      $rose(mode_o == PMC_ST_WAKE) |-> ##[1:600] mode_o == PMC_ST_RUN;
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake phase did not return to run");

   property p_ack;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack)
      else $error("bus acknowledge longer than one cycle");
endmodule // pmc_ctl_monitor

bind pmc_power_mode_clock_control pmc_ctl_monitor #(
   .WAKE_SUB_TICKS(WAKE_SUB_TICKS),
   .DIV_CW(DIV_CW)
) u_pmc_ctl_monitor (.clk_i, .reset_n_i, .wb_ack_o, .halt_i,
   .cpu_clock_tick_o, .system_clock_signal_o, .substitute_clock_o,
   .watchdog_clock_o, .watchdog_enable_o, .high_osc_enable_o,
   .low_osc_enable_o, .mode_o);

/* File: tb/tb_power_mode_clock_control.sv */
// Self-checking bench for the power mode clock controller.
`timescale 1ns/1ps
module tb_power_mode_clock_control;
   import pmc_pkg::*;
   logic        clk_i = 1'b0, reset_n_i = 1'b0;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
   logic        wb_ack_o, halt_i, wake_i, halt_req = 1'b0, wake_req = 1'b0;
   logic        o_xh, o_rc, o_ih, o_xl, o_il;
   logic        cpu, sys, sub, wdt, wdt_en, hi_en, lo_en;
   pmc_mode_t   mode_o;
   int          errors = 0, n_checks = 0, n_cpu, n_sys, n_sub, n_wdt;
   localparam logic [7:0] CM[6] = '{8'h01, 8'h01, 8'h01, 8'h01,
                                    8'h03, 8'h03};
   localparam logic [7:0] CC[6] = '{8'h0C, 8'h00, 8'h0E, 8'h04,
                                    8'h04, 8'h05};
   localparam pmc_mode_t EM[6] = '{PMC_ST_DEEP_SLEEP, PMC_ST_DEEP_SLEEP,
      PMC_ST_LIGHT_SLEEP, PMC_ST_LIGHT_SLEEP, PMC_ST_IDLE_OSC_OFF,
      PMC_ST_IDLE_OSC_ON};
   localparam int ES[6] = '{0, 0, 1, 1, 1, 1};
   localparam int EW[6] = '{0, 0, 1, 1, 0, 1};
   localparam int EY[6] = '{0, 0, 0, 0, 0, 1};

   always #5 clk_i = ~clk_i;

   pmc_core_model u_pmc_core_model (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .halt_req_i(halt_req), .wake_req_i(wake_req), .halt_o(halt_i),
      .wake_o(wake_i), .xtal_high_o(o_xh), .rc_ext_o(o_rc),
      .rc_high_o(o_ih), .xtal_low_o(o_xl), .rc_low_o(o_il));

   pmc_power_mode_clock_control #(.WAKE_SUB_TICKS(2), .DIV_CW(6))
   u_pmc_power_mode_clock_control (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .halt_i(halt_i),
      .wake_i(wake_i), .external_crystal_high_i(o_xh),
      .external_rc_oscillator_i(o_rc), .internal_rc_high_i(o_ih),
      .external_crystal_low_i(o_xl), .internal_rc_low_i(o_il),
      .cpu_clock_tick_o(cpu), .system_clock_signal_o(sys),
      .substitute_clock_o(sub), .watchdog_clock_o(wdt),
      .watchdog_enable_o(wdt_en), .high_osc_enable_o(hi_en),
      .low_osc_enable_o(lo_en), .mode_o(mode_o));

   task automatic conclude();
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Holds the request until ack is seen high, then releases it.
   task automatic wb(input logic we, input logic [3:0] a,
                     input logic [3:0] s, input logic [7:0] wd,
                     output logic [7:0] rd);
      int k;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= {24'h00_0000, wd};
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      if (wb_ack_o !== 1'b1) begin
         errors++;
         conclude();
      end
      rd = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] r;
      wb(1'b1, a, 4'hF, d, r);
   endtask

   task automatic rdc(input logic [3:0] a, input logic [7:0] m,
                      input logic [7:0] e);
      logic [7:0] r;
      wb(1'b0, a, 4'hF, 8'h00, r);
      check({24'h00_0000, r & m}, {24'h00_0000, e});
   endtask

   task automatic count(input int cyc);
      n_cpu = 0; n_sys = 0; n_sub = 0; n_wdt = 0;
      repeat (cyc) begin
         @(negedge clk_i);
         n_cpu += int'(cpu);
         n_sys += int'(sys);
         n_sub += int'(sub);
         n_wdt += int'(wdt);
      end
   endtask

   task automatic pulse(input logic w);
      @(posedge clk_i);
      if (w) wake_req <= 1'b1;
      else halt_req <= 1'b1;
      @(posedge clk_i);
      wake_req <= 1'b0;
      halt_req <= 1'b0;
   endtask

   initial begin
      logic [7:0] r;
      int k, n;
      repeat (3) @(posedge clk_i);
      reset_n_i <= 1'b1;
      rdc(PMC_OFS_MODE, PMC_MODE_WR_MASK, PMC_MODE_RST);
      rdc(PMC_OFS_CFG, 8'hFF, PMC_CFG_RST);
      rdc(PMC_OFS_STATUS, 8'h07, 8'h00);
      rdc(4'hC, 8'hFF, 8'h00);
      wb(1'b1, PMC_OFS_CFG, 4'h0, 8'hFF, r);
      rdc(PMC_OFS_CFG, 8'hFF, PMC_CFG_RST);
      wr(PMC_OFS_MODE, 8'hFF);
      rdc(PMC_OFS_MODE, PMC_MODE_WR_MASK, 8'hF3);
      for (int c = 2; c < 8; c++) begin
         wr(PMC_OFS_MODE, {3'(c), 5'h02});
         count(130);
         count(256);
         check(32'(n_sys), 32'(256 >> (8 - c)));
         check(32'(n_cpu), 32'(256 >> (8 - c)));
      end
      wr(PMC_OFS_MODE, 8'h03);
      for (int s = 0; s < 4; s++) begin
         wr(PMC_OFS_CFG, {1'b0, 2'(s), 5'h04});
         count(40);
         count(256);
         check(32'(n_sys), 32'(256 >> (s == 3 ? 2 : s)));
      end
      wr(PMC_OFS_MODE, 8'h02);
      for (int l = 0; l < 2; l++) begin
         wr(PMC_OFS_CFG, {3'h0, 1'(l), 4'h4});
         count(64);
         count(256);
         check(32'(n_sys), 32'(l == 1 ? 16 : 32));
         check({31'h0, hi_en}, 32'h0000_0000);
      end
      // Cases with the voltage detect bit clear act as compliant software.
      for (int i = 0; i < 6; i++) begin
         wr(PMC_OFS_MODE, CM[i]);
         wr(PMC_OFS_CFG, CC[i]);
         count(20);
         pulse(1'b0);
         count(4);
         check({29'h0, mode_o}, {29'h0, EM[i]});
         count(64);
         check(32'(n_cpu), 32'h0000_0000);
         check(32'(n_sub != 0), 32'(ES[i]));
         check(32'(n_wdt != 0), 32'(EW[i]));
         check(32'(n_sys != 0), 32'(EY[i]));
         check({31'h0, wdt_en},
               {31'h0, CC[i][2] && EM[i] != PMC_ST_DEEP_SLEEP});
         check({31'h0, lo_en}, 32'(ES[i]));
         pulse(1'b0);
         count(4);
         check({29'h0, mode_o}, {29'h0, EM[i]});
         pulse(1'b1);
         k = 0;
         n = 0;
         while (mode_o !== PMC_ST_RUN && k < 600) begin
            @(negedge clk_i);
            k++;
            if (mode_o === PMC_ST_WAKE) n += int'(cpu);
         end
         check(32'(k < 600), 32'h0000_0001);
         check(32'(n != 0), 32'h0000_0001);
      end
      conclude();
   end
endmodule // tb_power_mode_clock_control

/* File: verilog/pmc_power_mode_clock_control.sv */
// Operating mode controller and clock gating for the processor core.
`timescale 1ns/1ps

// Behaviour
// (RULE1) Normal run divides high clock 1 to 64.
// (RULE2) Normal clock from one high oscillator only.
// (RULE3) Slow mode uses low clock, high stopped.
// (RULE4) Halt with idle enable low enters sleep.
// (RULE5) Deep sleep stops core, substitute, watchdog clocks.
// (RULE6) Voltage detect on blocks deep sleep entry.
// (RULE7) Light sleep keeps substitute, watchdog when needed.
// (RULE8) Halt, idle high, keep low: idle oscillator off.
// (RULE9) Idle oscillator off stops oscillator and core.
// (RULE10) That idle gates watchdog clock by source.
// (RULE11) Halt, idle high, keep high: idle oscillator on.
// (RULE12) Idle oscillator on blocks core, oscillator runs.
// (RULE13) Idle oscillator on keeps watchdog clock running.
// (RULE14) One system mode register controls clocks.
// (RULE15) Clock select by high/low bit and divider.
// (RULE16) Wake-up runs core from substitute clock.
// (RULE17) Source and ratio switch without runt pulses.
module pmc_power_mode_clock_control #(
   parameter int WAKE_SUB_TICKS = 8,
   parameter int DIV_CW         = 6
) (
   input  wire logic               clk_i,
   input  wire logic               reset_n_i,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [3:0]         wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [31:0]        wb_dat_i,
   output logic      [31:0]        wb_dat_o,
   output logic                    wb_ack_o,
   input  wire logic               halt_i,
   input  wire logic               wake_i,
   input  wire logic               external_crystal_high_i,
   input  wire logic               external_rc_oscillator_i,
   input  wire logic               internal_rc_high_i,
   input  wire logic               external_crystal_low_i,
   input  wire logic               internal_rc_low_i,
   output logic                    cpu_clock_tick_o,
   output logic                    system_clock_signal_o,
   output logic                    substitute_clock_o,
   output logic                    watchdog_clock_o,
   output logic                    watchdog_enable_o,
   output logic                    high_osc_enable_o,
   output logic                    low_osc_enable_o,
   output pmc_pkg::pmc_mode_t      mode_o
);
   import pmc_pkg::*;

   localparam int WCW = $clog2(WAKE_SUB_TICKS + 1);

   // Decodes a bus address into a register hit; used by read and write.
   function automatic logic reg_hit(input logic [3:0] adr,
                                    input logic [3:0] ofs);
      reg_hit = (adr == ofs);
   endfunction

   // ------------------------------------------------------------------
   // Bus slave and register group.
   // ------------------------------------------------------------------
   logic [7:0]  mode_reg;
   logic [7:0]  next_mode_reg;
   logic [7:0]  cfg_reg;
   logic [7:0]  next_cfg_reg;
   logic        ack;
   logic        next_ack;
   logic [31:0] rd_data;
   logic [31:0] next_rd_data;
   logic        wr_now;
   logic [7:0]  mode_view;

   pmc_mode_t   state;
   pmc_mode_t   next_state;
   logic        high_run;
   logic        low_run;

   // Read view of the mode register shows live oscillator state.
   always_comb begin
      mode_view = mode_reg;
      mode_view[PMC_MODE_HRDY_BIT] = high_run;
      mode_view[PMC_MODE_LRDY_BIT] = low_run;
   end

   // A write takes effect at the edge where ack is sampled high.
   assign wr_now = wb_cyc_i && wb_stb_i && wb_we_i && ack && wb_sel_i[0];

   always_comb begin
      next_ack      = wb_cyc_i && wb_stb_i && !ack;
      next_rd_data  = rd_data;
      next_mode_reg = mode_reg;
      next_cfg_reg  = cfg_reg;
      if (wb_cyc_i && wb_stb_i && !ack) begin
         next_rd_data = PMC_ZERO_WORD;
         if (reg_hit(wb_adr_i, PMC_OFS_MODE)) begin
            next_rd_data[7:0] = mode_view;
         end else if (reg_hit(wb_adr_i, PMC_OFS_CFG)) begin
            next_rd_data[7:0] = cfg_reg;
         end else if (reg_hit(wb_adr_i, PMC_OFS_STATUS)) begin
            next_rd_data[2:0] = state;
         end
      end
      if (wr_now && reg_hit(wb_adr_i, PMC_OFS_MODE)) begin
         // Ready flags are read only; only writable bits are stored.
         next_mode_reg = (wb_dat_i[7:0] & PMC_MODE_WR_MASK) |
                         (mode_reg & ~PMC_MODE_WR_MASK); // RULE14
      end
      if (wr_now && reg_hit(wb_adr_i, PMC_OFS_CFG)) begin
         next_cfg_reg = wb_dat_i[7:0];
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ack      <= 1'b0;
         rd_data  <= PMC_ZERO_WORD;
         mode_reg <= PMC_MODE_RST;
         cfg_reg  <= PMC_CFG_RST;
      end else begin
         ack      <= next_ack;
         rd_data  <= next_rd_data;
         mode_reg <= next_mode_reg;
         cfg_reg  <= next_cfg_reg;
      end
   end

   assign wb_ack_o = ack;
   assign wb_dat_o = rd_data;

   // ------------------------------------------------------------------
   // Field extraction.
   // ------------------------------------------------------------------
   logic        hl_select;
   logic        idle_enable_bit;
   logic [2:0]  clock_divide_select;
   logic        idle_sysclk_keep_bit;
   logic        low_voltage_detect_enable;
   logic        wdt_on;
   logic        wdt_src_sys4;
   logic        ls_src_irc;
   pmc_hs_src_t hs_src;

   assign hl_select            = mode_reg[PMC_MODE_HIGH_LOW_CLOCK_SELECT_BIT];
   assign idle_enable_bit      = mode_reg[PMC_MODE_IDLE_BIT];
   assign clock_divide_select  = mode_reg[PMC_MODE_CKS_LSB +: 3];
   assign idle_sysclk_keep_bit = cfg_reg[PMC_CFG_KEEP_BIT];
   assign low_voltage_detect_enable = cfg_reg[PMC_CFG_LVD_BIT];
   assign wdt_on               = cfg_reg[PMC_CFG_WDTEN_BIT];
   assign wdt_src_sys4         = cfg_reg[PMC_CFG_WDTSRC_BIT];
   assign ls_src_irc           = cfg_reg[PMC_CFG_LSSRC_BIT];
   assign hs_src = pmc_hs_src_t'(cfg_reg[PMC_CFG_HSSRC_LSB +: 2]);

   // ------------------------------------------------------------------
   // Source selection and system clock divider.
   // ------------------------------------------------------------------
   logic       high_speed_clock;
   logic       low_speed_clock;
   logic       want_low;
   logic [2:0] want_log2;
   logic       sys_tick;
   logic       sys_on_low;
   logic       sys4_tick;

   // Exactly one high speed oscillator feeds the system clock; the
   // unused code falls back to the internal oscillator.
   always_comb begin
      unique case (hs_src)
         PMC_HS_XTAL: high_speed_clock = external_crystal_high_i; // RULE2
         PMC_HS_ERC:  high_speed_clock = external_rc_oscillator_i; // RULE2
         PMC_HS_IRC:  high_speed_clock = internal_rc_high_i;
         default:     high_speed_clock = internal_rc_high_i;
      endcase
   end

   assign low_speed_clock = ls_src_irc ? internal_rc_low_i
                                       : external_crystal_low_i;

   // High/low select set gives the undivided high clock; otherwise
   // the divide field picks the low clock or a power-of-two ratio.
   always_comb begin
      want_low  = 1'b0;
      want_log2 = PMC_LOG2_ONE;
      if (!hl_select) begin
         if (clock_divide_select <= PMC_CKS_LOW_MAX) begin
            want_low = 1'b1; // RULE15
         end else begin
            want_log2 = 3'(PMC_DIV_LOG2_TOP -
                           {1'b0, clock_divide_select}); // RULE1
         end
      end
   end

   pmc_tick_div #(
      .CW (DIV_CW)
   ) u_sys_div (
      .clk_i        (clk_i),
      .reset_n_i    (reset_n_i),
      .tick_a_i     (high_speed_clock),
      .tick_b_i     (low_speed_clock),
      .sel_b_i      (want_low),
      .ratio_log2_i (want_log2),
      .tick_o       (sys_tick),
      .sel_b_o      (sys_on_low)
   );

   pmc_tick_div #(
      .CW (DIV_CW)
   ) u_sys4_div (
      .clk_i        (clk_i),
      .reset_n_i    (reset_n_i),
      .tick_a_i     (sys_tick),
      .tick_b_i     (sys_tick),
      .sel_b_i      (1'b0),
      .ratio_log2_i (PMC_LOG2_SYS4),
      .tick_o       (sys4_tick),
      .sel_b_o      ()
   );

   // ------------------------------------------------------------------
   // Operating mode state machine.
   // ------------------------------------------------------------------
   logic [WCW-1:0] wake_cnt;
   logic [WCW-1:0] next_wake_cnt;
   logic           light_keep;

   // Light sleep keeps the low clocks only when something needs them.
   assign light_keep = low_voltage_detect_enable ||
                       (wdt_on && !wdt_src_sys4); // RULE7

   always_comb begin
      next_state    = state;
      next_wake_cnt = wake_cnt;
      unique case (state)
         PMC_ST_RUN: begin
            if (halt_i) begin
               if (!idle_enable_bit) begin
                  // Voltage detect on forbids the deep sleep.
                  if (low_voltage_detect_enable || light_keep) begin
                     next_state = PMC_ST_LIGHT_SLEEP; // RULE4 RULE6
                  end else begin
                     next_state = PMC_ST_DEEP_SLEEP; // RULE4
                  end
               end else if (!idle_sysclk_keep_bit) begin
                  next_state = PMC_ST_IDLE_OSC_OFF; // RULE8
               end else begin
                  next_state = PMC_ST_IDLE_OSC_ON; // RULE11
               end
            end
         end
         PMC_ST_DEEP_SLEEP,
         PMC_ST_LIGHT_SLEEP,
         PMC_ST_IDLE_OSC_OFF,
         PMC_ST_IDLE_OSC_ON: begin
            if (wake_i) begin
               next_state    = PMC_ST_WAKE;
               next_wake_cnt = '0;
            end
         end
         PMC_ST_WAKE: begin
            // The core runs on the substitute clock while the main
            // oscillator settles, which shortens the wake-up time.
            if (low_speed_clock) begin
               if (wake_cnt == WCW'(WAKE_SUB_TICKS - 1)) begin
                  next_state = PMC_ST_RUN; // RULE16
               end else begin
                  next_wake_cnt = wake_cnt + WCW'(1);
               end
            end
         end
         default: next_state = PMC_ST_RUN;
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state    <= PMC_ST_RUN;
         wake_cnt <= '0;
      end else begin
         state    <= next_state;
         wake_cnt <= next_wake_cnt;
      end
   end

   // ------------------------------------------------------------------
   // Oscillator enables and clock gates.
   // ------------------------------------------------------------------
   logic sys_gate;
   logic sub_gate;
   logic wdt_gate;
   logic cpu_sel_sys;
   logic cpu_sel_sub;
   logic next_cpu_tick;
   logic next_sys_out;
   logic next_sub_out;
   logic next_wdt_out;
   logic next_wdt_en;
   logic wdt_src_tick;

   // In run the high oscillator stays on while the request or the divider's
   // latched source is high, so it is not stopped before the switch has completed.
   always_comb begin
      high_run    = 1'b0;
      low_run     = 1'b1;
      sys_gate    = 1'b0;
      sub_gate    = 1'b1;
      wdt_gate    = 1'b1;
      cpu_sel_sys = 1'b0;
      cpu_sel_sub = 1'b0;
      unique case (state)
         PMC_ST_RUN: begin
            high_run    = !sys_on_low || !want_low; // RULE3
            sys_gate    = 1'b1;
            cpu_sel_sys = 1'b1;
         end
         PMC_ST_WAKE: begin
            high_run    = !want_low;
            sys_gate    = 1'b1;
            cpu_sel_sub = 1'b1; // RULE16
         end
         PMC_ST_DEEP_SLEEP: begin
            low_run  = 1'b0; // RULE5
            sub_gate = 1'b0; // RULE5
            wdt_gate = 1'b0; // RULE5
         end
         PMC_ST_LIGHT_SLEEP: begin
            low_run  = light_keep; // RULE7
            sub_gate = light_keep; // RULE7
            wdt_gate = light_keep; // RULE7
         end
         PMC_ST_IDLE_OSC_OFF: begin
            wdt_gate = wdt_src_sys4; // RULE9 RULE10
         end
         PMC_ST_IDLE_OSC_ON: begin
            high_run = !sys_on_low; // RULE12
            sys_gate = 1'b1; // RULE12
            wdt_gate = 1'b1; // RULE13
         end
         default: begin
            high_run = 1'b0;
         end
      endcase
   end

   assign wdt_src_tick = wdt_src_sys4 ? sys4_tick : low_speed_clock;

   always_comb begin
      next_cpu_tick = (cpu_sel_sys && sys_tick) ||
                      (cpu_sel_sub && low_speed_clock);
      next_sys_out  = sys_gate && sys_tick;
      next_sub_out  = sub_gate && low_run && low_speed_clock;
      next_wdt_out  = wdt_gate && wdt_src_tick;
      next_wdt_en   = wdt_on && (state != PMC_ST_DEEP_SLEEP); // RULE5
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cpu_clock_tick_o      <= 1'b0;
         system_clock_signal_o <= 1'b0;
         substitute_clock_o    <= 1'b0;
         watchdog_clock_o      <= 1'b0;
         watchdog_enable_o     <= 1'b0;
         high_osc_enable_o     <= 1'b0;
         low_osc_enable_o      <= 1'b0;
         mode_o                <= PMC_ST_RUN;
      end else begin
         cpu_clock_tick_o      <= next_cpu_tick;
         system_clock_signal_o <= next_sys_out;
         substitute_clock_o    <= next_sub_out;
         watchdog_clock_o      <= next_wdt_out;
         watchdog_enable_o     <= next_wdt_en;
         high_osc_enable_o     <= high_run;
         low_osc_enable_o      <= low_run;
         mode_o                <= state;
      end
   end

endmodule // pmc_power_mode_clock_control

/* File: verilog/pmc_tick_div.sv */
// Glitch-free tick divider with a two-way source select.
`timescale 1ns/1ps
module pmc_tick_div #(
   parameter int CW = 6
) (
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       tick_a_i,
   input  wire logic       tick_b_i,
   input  wire logic       sel_b_i,
   input  wire logic [2:0] ratio_log2_i,
   output logic            tick_o,
   output logic            sel_b_o
);
   import pmc_pkg::*;

   logic [CW-1:0] cnt;
   logic [CW-1:0] next_cnt;
   logic [2:0]    ratio;
   logic [2:0]    next_ratio;
   logic          sel;
   logic          next_sel;
   logic          next_tick;
   logic          src_tick;
   logic [CW-1:0] limit;

   assign src_tick = sel ? tick_b_i : tick_a_i;
   assign limit    = CW'((32'd1 << ratio) - 32'd1);
   assign sel_b_o  = sel;

   // Source and ratio change only at a period boundary, so the output
   // never carries a shortened period while a switch is in progress.
   always_comb begin
      next_cnt   = cnt;
      next_ratio = ratio;
      next_sel   = sel;
      next_tick  = 1'b0;
      if (src_tick) begin
         if (cnt == limit) begin
            next_cnt   = '0;
            next_tick  = 1'b1;
            next_ratio = ratio_log2_i; // RULE17
            next_sel   = sel_b_i;      // RULE17
         end else begin
            next_cnt = cnt + CW'(1);
         end
      end else if (cnt == '0) begin
         next_ratio = ratio_log2_i;
         next_sel   = sel_b_i;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt    <= '0;
         ratio  <= PMC_LOG2_ONE;
         sel    <= 1'b0;
         tick_o <= 1'b0;
      end else begin
         cnt    <= next_cnt;
         ratio  <= next_ratio;
         sel    <= next_sel;
         tick_o <= next_tick;
      end
   end

endmodule // pmc_tick_div
